// ===== rtl/psm_pkg.sv
// Shared constants, state codes and helpers of the power mode sequencer
package psm_pkg;

  localparam int unsigned APB_AW          = 12;
  localparam int unsigned APB_DW          = 32;
  localparam logic [11:0] CTRL_OFS        = 12'h000;
  localparam logic [11:0] STAT_OFS        = 12'h004;

  localparam int unsigned CTRL_SLOW_BIT   = 0;
  localparam int unsigned CTRL_DIV_LSB    = 1;
  localparam int unsigned CTRL_OIE_BIT    = 3;
  localparam int unsigned CTRL_W          = 4;
  localparam logic [3:0]  CTRL_RESET      = 4'h0;

  localparam int unsigned STAT_MODE_LSB   = 0;
  localparam int unsigned STAT_LONG_BIT   = 3;
  localparam int unsigned STAT_CAUSE_BIT  = 4;

  localparam logic [1:0]  IMASK_WAKE      = 2'b10;

  localparam int unsigned STAB_SHORT_CYC  = 256;
  localparam int unsigned STAB_LONG_CYC   = 4096;
  localparam int unsigned STAB_CW         = 13;

  localparam int unsigned DIV_CW          = 4;

  typedef enum logic [2:0] {
    ST_RUN   = 3'b000,
    ST_WAIT  = 3'b001,
    ST_AHALT = 3'b011,
    ST_HALT  = 3'b010,
    ST_STAB  = 3'b110
  } psm_state_t;

  localparam logic [2:0]  MODE_RUN        = 3'h0;
  localparam logic [2:0]  MODE_SLOW       = 3'h1;
  localparam logic [2:0]  MODE_WAIT       = 3'h2;
  localparam logic [2:0]  MODE_SLOW_WAIT  = 3'h3;
  localparam logic [2:0]  MODE_AHALT      = 3'h4;
  localparam logic [2:0]  MODE_HALT       = 3'h5;
  localparam logic [2:0]  MODE_STAB       = 3'h6;

  // Divide by 2, 4, 8 or 16: terminal count of the slow divider
  function automatic logic [3:0] psm_div_mask(input logic [1:0] sel);
    logic [4:0] span;
    span = 5'h02 << sel;
    return 4'(span - 5'h01);
  endfunction : psm_div_mask

endpackage : psm_pkg

// ===== rtl/psm_clkdiv.sv
// Slow mode divider producing the reduced core clock enable tick
module psm_clkdiv (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       slow_mode_enable,
  input  wire logic [1:0] slow_divider_select,
  output logic            tick
);

  logic [psm_pkg::DIV_CW-1:0] cnt;
  logic [psm_pkg::DIV_CW-1:0] mask;
  logic                       wrap;

  assign mask = psm_pkg::psm_div_mask(slow_divider_select);
  assign wrap = (cnt >= mask);

  // Divided tick when slow, every cycle otherwise
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else begin
      cnt  <= (wrap || !slow_mode_enable) ? '0 : cnt + 4'h1;
      tick <= !slow_mode_enable || wrap;
    end
  end

endmodule : psm_clkdiv

// ===== rtl/psm_ctrl.sv
// Power saving mode sequencer with APB control and status registers
//
// Behaviour
// - After reset the block starts in run mode at the full master clock.
// - Slow mode uses one enable bit and two divider select bits.
// - Slow mode divides master clock by 2, 4, 8 or 16 for CPU and peripherals.
// - Wait entered while slow keeps the divided clock running.
// - Wait instruction stops the CPU; peripherals keep running.
// - Entering wait forces the interrupt mask bits to binary 10.
// - Wait leaves all other registers and memory untouched.
// - Wait ends on interrupt or reset, then vectors to the matching routine.
// - Before servicing, condition codes are stacked and mask set to routine level.
// - Halt instruction enters halt when oscillator interrupt enable is 0, else active-halt.
// - Active-halt keeps only oscillator and time base counter clocked.
// - Active-halt ends on time base, wake interrupt or reset; interrupts skip delay.
// - Leaving active-halt applies the start-up delay only for reset.
// - Entering either halt forces mask to 10; pending wake exits at once.
// - With oscillator interrupt enabled, active-halt never causes a watchdog reset.
// - Halt stops the oscillator and every internally clocked peripheral.
// - Halt ends on wake interrupt or reset after a 256 or 4096 cycle delay.
// - Watchdog halt option decides whether halt with watchdog on resets.
module psm_ctrl #(
  parameter int unsigned STAB_SHORT = psm_pkg::STAB_SHORT_CYC,
  parameter int unsigned STAB_LONG  = psm_pkg::STAB_LONG_CYC
) (
  input  wire logic                       clk_sys,
  input  wire logic                       rstn,
  input  wire logic [psm_pkg::APB_AW-1:0] paddr,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [psm_pkg::APB_DW-1:0] pwdata,
  output logic      [psm_pkg::APB_DW-1:0] prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       wait_for_interrupt_instr,
  input  wire logic                       halt_instr,
  input  wire logic                       irq_pending,
  input  wire logic                       irq_wake,
  input  wire logic                       timebase_irq,
  input  wire logic                       reset_req,
  input  wire logic                       watchdog_enabled,
  input  wire logic                       watchdog_halt_option,
  input  wire logic                       stab_long_sel,
  output logic                            osc_enable,
  output logic                            cpu_clk_en,
  output logic                            periph_clk_en,
  output logic                            timebase_clk_en,
  output logic                            cpu_stopped,
  output logic                            force_imask,
  output logic      [1:0]                 imask_value,
  output logic                            irq_vector_fetch,
  output logic                            reset_vector_fetch,
  output logic                            watchdog_halt_reset,
  output logic      [2:0]                 mode_code
);

  psm_pkg::psm_state_t state;
  psm_pkg::psm_state_t next_state;

  logic [psm_pkg::CTRL_W-1:0]  ctrl;
  logic [psm_pkg::STAB_CW-1:0] stab_cnt;
  logic                        stab_long_q;
  logic                        wake_by_reset;
  logic                        tick;

  logic                        slow_mode_enable;
  logic [1:0]                  slow_divider_select;
  logic                        oscillator_interrupt_enable;

  logic                        next_fetch_irq;
  logic                        next_fetch_rst;
  logic                        next_force;
  logic                        next_wdg_rst;

  // Register bus decode
  logic                        apb_setup;
  logic                        apb_write;
  logic                        hit_ctrl;
  logic                        hit_stat;
  logic [psm_pkg::APB_DW-1:0]  rd_mux;
  logic [2:0]                  next_mode;
  logic                        stab_load;
  logic                        stab_done;
  logic [psm_pkg::STAB_CW-1:0] stab_init;

  assign slow_mode_enable            = ctrl[psm_pkg::CTRL_SLOW_BIT];
  assign slow_divider_select         = ctrl[psm_pkg::CTRL_DIV_LSB +: 2];
  assign oscillator_interrupt_enable = ctrl[psm_pkg::CTRL_OIE_BIT];

  assign apb_setup = psel && !penable;
  assign apb_write = psel && penable && pwrite && pready;
  assign hit_ctrl  = (paddr == psm_pkg::CTRL_OFS);
  assign hit_stat  = (paddr == psm_pkg::STAT_OFS);

  assign rd_mux = hit_ctrl ? 32'(ctrl) :
                  hit_stat ? 32'({wake_by_reset, stab_long_q, mode_code}) :
                  32'h0000_0000;

  // Slow divider runs from the master clock in every state, halt included
  psm_clkdiv u_div (
    .clk_sys             (clk_sys),
    .rstn                (rstn),
    .slow_mode_enable    (slow_mode_enable),
    .slow_divider_select (slow_divider_select),
    .tick                (tick)
  );

  // Mode sequencer
  always_comb begin
    next_state     = state;
    next_fetch_irq = 1'b0;
    next_fetch_rst = 1'b0;
    next_force     = 1'b0;
    next_wdg_rst   = 1'b0;
    case (state)
      psm_pkg::ST_RUN: begin
        if (reset_req) begin
          next_fetch_rst = 1'b1;
        end else if (halt_instr) begin
          if (oscillator_interrupt_enable) begin
            next_state = psm_pkg::ST_AHALT;
            next_force = 1'b1;
          end else if (watchdog_enabled && watchdog_halt_option) begin
            next_wdg_rst = 1'b1;
          end else begin
            next_state = psm_pkg::ST_HALT;
            next_force = 1'b1;
          end
        end else if (wait_for_interrupt_instr) begin
          next_state = psm_pkg::ST_WAIT;
          next_force = 1'b1;
        end
      end
      psm_pkg::ST_WAIT: begin
        if (reset_req) begin
          next_state     = psm_pkg::ST_RUN;
          next_fetch_rst = 1'b1;
        end else if (irq_pending) begin
          next_state     = psm_pkg::ST_RUN;
          next_fetch_irq = 1'b1;
        end
      end
      psm_pkg::ST_AHALT: begin
        if (reset_req) begin
          next_state = psm_pkg::ST_STAB;
        end else if (timebase_irq || irq_wake) begin
          next_state     = psm_pkg::ST_RUN;
          next_fetch_irq = 1'b1;
        end
      end
      psm_pkg::ST_HALT: begin
        if (reset_req || irq_wake) begin
          next_state = psm_pkg::ST_STAB;
        end
      end
      psm_pkg::ST_STAB: begin
        if (stab_done && !reset_req) begin
          next_state     = psm_pkg::ST_RUN;
          next_fetch_irq = !wake_by_reset;
          next_fetch_rst = wake_by_reset;
        end
      end
      default: begin
        next_state = psm_pkg::ST_RUN;
      end
    endcase
  end

  assign stab_load = (next_state == psm_pkg::ST_STAB) && (state != psm_pkg::ST_STAB);
  assign stab_done = (stab_cnt == '0);
  assign stab_init = stab_long_sel ? psm_pkg::STAB_CW'(STAB_LONG - 1)
                                   : psm_pkg::STAB_CW'(STAB_SHORT - 1);

  always_comb begin
    case (next_state)
      psm_pkg::ST_RUN:   next_mode = slow_mode_enable ? psm_pkg::MODE_SLOW
                                                      : psm_pkg::MODE_RUN;
      psm_pkg::ST_WAIT:  next_mode = slow_mode_enable ? psm_pkg::MODE_SLOW_WAIT
                                                      : psm_pkg::MODE_WAIT;
      psm_pkg::ST_AHALT: next_mode = psm_pkg::MODE_AHALT;
      psm_pkg::ST_HALT:  next_mode = psm_pkg::MODE_HALT;
      default:           next_mode = psm_pkg::MODE_STAB;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state <= psm_pkg::ST_RUN;
      ctrl  <= psm_pkg::CTRL_RESET;
    end else begin
      state <= next_state;
      if (apb_write && hit_ctrl) begin
        ctrl <= pwdata[psm_pkg::CTRL_W-1:0];
      end
    end
  end

  // Exit delay; a reset arriving mid delay marks it as a reset exit without restarting the count
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      stab_cnt      <= '0;
      stab_long_q   <= 1'b0;
      wake_by_reset <= 1'b0;
    end else begin
      if (stab_load) begin
        stab_cnt      <= stab_init;
        stab_long_q   <= stab_long_sel;
        wake_by_reset <= reset_req;
      end else if (state == psm_pkg::ST_STAB) begin
        stab_cnt      <= stab_done ? stab_cnt : stab_cnt - 13'h0001;
        wake_by_reset <= wake_by_reset || reset_req;
      end
    end
  end

  // Clock gating; outputs follow the state they belong to
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      osc_enable      <= 1'b1;
      cpu_clk_en      <= 1'b0;
      periph_clk_en   <= 1'b0;
      timebase_clk_en <= 1'b0;
      cpu_stopped     <= 1'b0;
      mode_code       <= psm_pkg::MODE_RUN;
    end else begin
      osc_enable      <= (next_state != psm_pkg::ST_HALT);
      cpu_clk_en      <= tick && (next_state == psm_pkg::ST_RUN);
      periph_clk_en   <= tick && ((next_state == psm_pkg::ST_RUN) ||
                                  (next_state == psm_pkg::ST_WAIT));
      timebase_clk_en <= (next_state != psm_pkg::ST_HALT);
      cpu_stopped     <= (next_state != psm_pkg::ST_RUN);
      mode_code       <= next_mode;
    end
  end

  // Only the mask bits are touched on entry, nothing else of the core
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      force_imask         <= 1'b0;
      imask_value         <= psm_pkg::IMASK_WAKE;
      irq_vector_fetch    <= 1'b0;
      reset_vector_fetch  <= 1'b0;
      watchdog_halt_reset <= 1'b0;
    end else begin
      force_imask         <= next_force;
      imask_value         <= psm_pkg::IMASK_WAKE;
      irq_vector_fetch    <= next_fetch_irq;
      reset_vector_fetch  <= next_fetch_rst;
      watchdog_halt_reset <= next_wdg_rst;
    end
  end

  // Zero wait slave: read data prepared in the setup cycle
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (apb_setup) begin
        prdata  <= pwrite ? '0 : rd_mux;
        pslverr <= !(hit_ctrl || hit_stat);
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence s_run_halt_oie;
    state == psm_pkg::ST_RUN && !reset_req && halt_instr && oscillator_interrupt_enable;
  endsequence

  sequence s_enter_stab;
    state != psm_pkg::ST_STAB ##1 state == psm_pkg::ST_STAB;
  endsequence

  property p_wait_entry;
    state == psm_pkg::ST_RUN && !reset_req && !halt_instr && wait_for_interrupt_instr
      |=> state == psm_pkg::ST_WAIT && force_imask && imask_value == 2'b10
          && cpu_stopped && !cpu_clk_en;
  endproperty
  a_wait_entry: assert property (p_wait_entry) else $error("wait entry wrong");

  property p_ahalt_entry;
    s_run_halt_oie |=> state == psm_pkg::ST_AHALT && force_imask && !watchdog_halt_reset;
  endproperty
  a_ahalt_entry: assert property (p_ahalt_entry) else $error("active-halt entry wrong");

  property p_wdg_halt;
    state == psm_pkg::ST_RUN && !reset_req && halt_instr && !oscillator_interrupt_enable
      && watchdog_enabled && watchdog_halt_option
      |=> watchdog_halt_reset && state == psm_pkg::ST_RUN;
  endproperty
  a_wdg_halt: assert property (p_wdg_halt) else $error("watchdog halt reset missing");

  property p_halt_clocks;
    state == psm_pkg::ST_HALT |-> !osc_enable && !periph_clk_en && !cpu_clk_en
                                  && !timebase_clk_en;
  endproperty
  a_halt_clocks: assert property (p_halt_clocks) else $error("clock alive in halt");

  property p_ahalt_clocks;
    state == psm_pkg::ST_AHALT |-> osc_enable && timebase_clk_en && !periph_clk_en;
  endproperty
  a_ahalt_clocks: assert property (p_ahalt_clocks) else $error("active-halt clocks wrong");

  property p_ahalt_irq_exit;
    state == psm_pkg::ST_AHALT && !reset_req && (timebase_irq || irq_wake)
      |=> state == psm_pkg::ST_RUN && irq_vector_fetch;
  endproperty
  a_ahalt_irq_exit: assert property (p_ahalt_irq_exit) else $error("active-halt wake slow");

  property p_ahalt_reset_exit;
    state == psm_pkg::ST_AHALT && reset_req |=> state == psm_pkg::ST_STAB && wake_by_reset;
  endproperty
  a_ahalt_reset_exit: assert property (p_ahalt_reset_exit) else $error("reset delay skipped");

  property p_stab_load;
    s_enter_stab |-> stab_cnt == (stab_long_q ? 13'(STAB_LONG - 1) : 13'(STAB_SHORT - 1));
  endproperty
  a_stab_load: assert property (p_stab_load) else $error("delay length wrong");

  property p_stab_exit;
    state == psm_pkg::ST_STAB ##1 state == psm_pkg::ST_RUN
      |-> $past(stab_cnt) == 13'h0000 && (irq_vector_fetch ^ reset_vector_fetch);
  endproperty
  a_stab_exit: assert property (p_stab_exit) else $error("delay ended early");

  property p_wait_exit;
    state == psm_pkg::ST_WAIT && irq_pending && !reset_req
      |=> state == psm_pkg::ST_RUN && irq_vector_fetch ##1 !irq_vector_fetch;
  endproperty
  a_wait_exit: assert property (p_wait_exit) else $error("wait exit wrong");

  property p_slow_tick;
    state == psm_pkg::ST_RUN && slow_mode_enable && cpu_clk_en
      && $stable(ctrl) |=> !cpu_clk_en;
  endproperty
  a_slow_tick: assert property (p_slow_tick) else $error("slow clock not divided");

endmodule : psm_ctrl

// ===== sim/psm_core_model.sv
// Core, interrupt sources and reset request facing the power mode sequencer
module psm_core_model #(
  parameter logic [1:0] ISR_LEVEL = 2'b01
) (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       force_imask,
  input  wire logic [1:0] imask_value,
  input  wire logic       irq_vector_fetch,
  output logic            wait_for_interrupt_instr,
  output logic            halt_instr,
  output logic            irq_pending,
  output logic            irq_wake,
  output logic            timebase_irq,
  output logic            reset_req,
  output logic [1:0]      cc_mask,
  output logic [1:0]      cc_stacked
);
  initial begin
    {wait_for_interrupt_instr, halt_instr, reset_req} = 3'h0;
    {irq_pending, irq_wake, timebase_irq} = 3'h0;
  end
  // Requests stay latched until their vector is fetched, no earlier
  always @(posedge clk_sys) begin
    if (irq_vector_fetch) begin
      {irq_pending, irq_wake, timebase_irq} <= 3'h0;
    end
  end
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cc_mask    <= 2'b11;
      cc_stacked <= 2'b11;
    end else if (irq_vector_fetch) begin
      cc_stacked <= cc_mask;
      cc_mask    <= ISR_LEVEL;
    end else if (force_imask) begin
      cc_mask <= imask_value;
    end
  end
  // One-cycle pulse: 0 wait, 1 halt, else reset request
  task automatic pulse(input int k);
    case (k)
      0: wait_for_interrupt_instr <= 1'b1;
      1: halt_instr <= 1'b1;
      default: reset_req <= 1'b1;
    endcase
    @(posedge clk_sys);
    {wait_for_interrupt_instr, halt_instr, reset_req} <= 3'h0;
  endtask : pulse
  task automatic raise(input int k);
    case (k)
      0: irq_pending <= 1'b1;
      1: irq_wake <= 1'b1;
      default: timebase_irq <= 1'b1;
    endcase
  endtask : raise
endmodule : psm_core_model

// ===== sim/psm_ctrl_bench.sv
// Self-checking bench of the power mode sequencer
module psm_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // Short delays keep the run brief
  localparam int unsigned NS = 4;
  localparam int unsigned NL = 8;
  logic        clk_sys, rstn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        watchdog_enabled, watchdog_halt_option, stab_long_sel;
  logic        wait_for_interrupt_instr, halt_instr, irq_pending, irq_wake;
  logic        timebase_irq, reset_req, osc_enable, cpu_clk_en, periph_clk_en;
  logic        timebase_clk_en, cpu_stopped, force_imask, irq_vector_fetch;
  logic        reset_vector_fetch, watchdog_halt_reset;
  logic [1:0]  imask_value, cc_mask, cc_stacked;
  logic [2:0]  mode_code;
  int          n_fail, checks, n, c, p;
  wire  [3:0]  ev = {watchdog_halt_reset, reset_vector_fetch, irq_vector_fetch, force_imask};

  psm_ctrl #(.STAB_SHORT(NS), .STAB_LONG(NL)) dut (
    .clk_sys                  (clk_sys),
    .rstn                     (rstn),
    .paddr                    (paddr),
    .psel                     (psel),
    .penable                  (penable),
    .pwrite                   (pwrite),
    .pwdata                   (pwdata),
    .prdata                   (prdata),
    .pready                   (pready),
    .pslverr                  (pslverr),
    .wait_for_interrupt_instr (wait_for_interrupt_instr),
    .halt_instr               (halt_instr),
    .irq_pending              (irq_pending),
    .irq_wake                 (irq_wake),
    .timebase_irq             (timebase_irq),
    .reset_req                (reset_req),
    .watchdog_enabled         (watchdog_enabled),
    .watchdog_halt_option     (watchdog_halt_option),
    .stab_long_sel            (stab_long_sel),
    .osc_enable               (osc_enable),
    .cpu_clk_en               (cpu_clk_en),
    .periph_clk_en            (periph_clk_en),
    .timebase_clk_en          (timebase_clk_en),
    .cpu_stopped              (cpu_stopped),
    .force_imask              (force_imask),
    .imask_value              (imask_value),
    .irq_vector_fetch         (irq_vector_fetch),
    .reset_vector_fetch       (reset_vector_fetch),
    .watchdog_halt_reset      (watchdog_halt_reset),
    .mode_code                (mode_code)
  );
  psm_core_model core (
    .clk_sys                  (clk_sys),
    .rstn                     (rstn),
    .force_imask              (force_imask),
    .imask_value              (imask_value),
    .irq_vector_fetch         (irq_vector_fetch),
    .wait_for_interrupt_instr (wait_for_interrupt_instr),
    .halt_instr               (halt_instr),
    .irq_pending              (irq_pending),
    .irq_wake                 (irq_wake),
    .timebase_irq             (timebase_irq),
    .reset_req                (reset_req),
    .cc_mask                  (cc_mask),
    .cc_stacked               (cc_stacked)
  );

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Idle cycle after each transfer so no strobe is set twice at one edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  // 64 is a multiple of every divide ratio, so counts are exact
  task automatic ticks();
    c = 0;
    p = 0;
    repeat (20) @(posedge clk_sys);
    repeat (64) begin
      @(posedge clk_sys);
      c += int'(cpu_clk_en);
      p += int'(periph_clk_en);
    end
  endtask : ticks
  task automatic wait_ev(input int k, input int lim);
    n = -1;
    for (int i = 1; i <= lim && n < 0; i++) begin
      @(posedge clk_sys);
      if (ev[k] === 1'b1) n = i;
    end
  endtask : wait_ev
  task automatic conclude();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial begin
    #400000;
    n_fail++;
    conclude();
  end
  initial begin
    {rstn, psel, penable, pwrite} = 4'h0;
    {watchdog_enabled, watchdog_halt_option, stab_long_sel} = 3'h0;
    paddr  = 12'h000;
    pwdata = 32'h0;
    n_fail = 0;
    checks = 0;
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    chk("mode", 0, mode_code);
    apb(0, psm_pkg::CTRL_OFS, 0);
    chk("ctrl", 0, rd);
    ticks();
    chk("run ticks", 64, c);
    for (int s = 0; s < 4; s++) begin
      apb(1, psm_pkg::CTRL_OFS, {29'h0, s[1:0], 1'b1});
      ticks();
      chk("slow core", 64 >> (s + 1), c);
      chk("slow periph", 64 >> (s + 1), p);
      chk("mode", psm_pkg::MODE_SLOW, mode_code);
    end
    core.pulse(0);
    #1;
    chk("mode", psm_pkg::MODE_SLOW_WAIT, mode_code);
    chk("stopped", 1, cpu_stopped);
    ticks();
    chk("wait core", 0, c);
    chk("wait periph", 4, p);
    chk("mask", 2'b10, cc_mask);
    apb(0, psm_pkg::CTRL_OFS, 0);
    chk("ctrl kept", 32'h7, rd);
    core.raise(0);
    wait_ev(1, 8);
    chk("wait wake", 2, n);
    #1;
    chk("stacked", 2'b10, cc_stacked);
    chk("mode", psm_pkg::MODE_SLOW, mode_code);
    @(posedge clk_sys);
    apb(1, psm_pkg::STAT_OFS, 32'hffffffff);
    apb(0, psm_pkg::STAT_OFS, 0);
    chk("status", 32'h1, rd);
    apb(0, 12'h008, 0);
    chk("unmapped err", 1, err);
    chk("unmapped data", 0, rd);
    apb(1, psm_pkg::CTRL_OFS, 32'hffffffff);
    apb(0, psm_pkg::CTRL_OFS, 0);
    chk("ctrl bits", 32'hf, rd);
    apb(1, psm_pkg::CTRL_OFS, 32'h8);
    watchdog_enabled     <= 1'b1;
    watchdog_halt_option <= 1'b1;
    core.pulse(1);
    #1;
    chk("mode", psm_pkg::MODE_AHALT, mode_code);
    chk("timebase clk", 1, timebase_clk_en);
    wait_ev(3, 4);
    chk("no wdg reset", -1, n);
    ticks();
    chk("ahalt periph", 0, p);
    core.raise(2);
    wait_ev(1, 8);
    chk("ahalt wake", 2, n);
    core.pulse(1);
    @(posedge clk_sys);
    core.pulse(2);
    #1;
    chk("mode", psm_pkg::MODE_STAB, mode_code);
    wait_ev(2, 20);
    chk("ahalt reset exit", NS + 1, n);
    apb(0, psm_pkg::STAT_OFS, 0);
    chk("reset cause", 32'h10, rd & 32'h10);
    apb(1, psm_pkg::CTRL_OFS, 32'h0);
    watchdog_enabled <= 1'b0;
    stab_long_sel    <= 1'b1;
    core.pulse(1);
    #1;
    chk("mode", psm_pkg::MODE_HALT, mode_code);
    chk("osc", 0, osc_enable);
    ticks();
    chk("halt periph", 0, p);
    core.raise(2);
    wait_ev(1, 4);
    chk("timebase in halt", -1, n);
    core.raise(1);
    wait_ev(1, 20);
    chk("halt wake", NL + 2, n);
    apb(0, psm_pkg::STAT_OFS, 0);
    chk("long sel", 32'h8, rd & 32'h8);
    apb(1, psm_pkg::CTRL_OFS, 32'h8);
    core.raise(1);
    @(posedge clk_sys);
    core.pulse(1);
    wait_ev(1, 6);
    chk("pending wake", 2, n);
    #1;
    chk("forced mask", 2'b10, cc_stacked);
    @(posedge clk_sys);
    apb(1, psm_pkg::CTRL_OFS, 32'h0);
    watchdog_enabled <= 1'b1;
    core.pulse(1);
    wait_ev(3, 4);
    chk("wdg reset", 1, n);
    #1;
    chk("mode", 0, mode_code);
    @(posedge clk_sys);
    watchdog_halt_option <= 1'b0;
    core.pulse(1);
    wait_ev(3, 4);
    chk("no wdg reset", -1, n);
    core.pulse(2);
    wait_ev(2, 20);
    chk("halt reset exit", NL + 1, n);
    conclude();
  end
endmodule : psm_ctrl_bench
